// file: inc/suc_pkg.sv
package suc_pkg;
   // System clock rate; one bit time of IrDA at 115.2 kbps is ~347 cycles
   localparam int unsigned SUC_CLK_HZ = 40_000_000;
   localparam int SUC_DW = 9;          // Widest data field
   localparam int SUC_FW = 13;         // Start + 9 data + parity + 2 stop
   localparam int SUC_RW = 11;         // Received data + parity + stop
   localparam int SUC_SPI_W = 8;       // Master SPI word
   localparam int SUC_PH_W = 16;       // Fractional baud accumulator
   localparam int SUC_TP_W = 16;       // Measured tick period
   localparam int SUC_RXE_W = 12;      // Stored receive entry
   localparam int SUC_FERR_BIT = 9;
   localparam int SUC_PERR_BIT = 10;
   localparam int SUC_OVR_BIT = 11;
   localparam logic [2:0] SUC_OS_LAST = 3'h7;  // Eight ticks per async bit
   localparam logic [2:0] SUC_OS_VOTE = 3'h5;  // Votes on ticks 3, 4, 5
   localparam logic [2:0] SUC_OS_FIRST = 3'h1;
   localparam logic [2:0] SUC_CHSZ_9 = 3'h7;
   localparam logic [3:0] SUC_MIN_BITS = 4'h5;
   localparam logic [3:0] SUC_LEN_9 = 4'h9;
   localparam logic [3:0] SUC_SPI_BITS = 4'h8;
   localparam logic [3:0] SUC_START_STOP = 4'h2;
   localparam logic [3:0] SUC_STOP_BITS = 4'h1;
   localparam logic [1:0] SUC_IR_FILT = 2'h2;  // Clocks a pulse must last
   localparam logic [2:0] SUC_IR_HOLD = 3'h6;  // Ticks a pulse reads as 0

   typedef enum logic [1:0] {SUC_ASYNC, SUC_SYNC_MST, SUC_SYNC_SLV,
      SUC_SPI_MST} suc_mode_t;
   typedef enum logic [1:0] {SUC_IR_316, SUC_IR_FIXED, SUC_IR_OFF} suc_ir_t;
   typedef enum logic [1:0] {SUC_RX_IDLE, SUC_RX_START, SUC_RX_BITS}
      suc_rx_st_t;
   typedef enum logic {SUC_TX_IDLE, SUC_TX_BUSY} suc_tx_st_t;

   // Character size code to data bit count; codes 4 to 6 act as 9 bits
   function automatic logic [3:0] suc_data_len(input logic [2:0] code);
      if (code[2]) begin
         suc_data_len = SUC_LEN_9;
      end else begin
         suc_data_len = SUC_MIN_BITS + {2'b00, code[1:0]};
      end
   endfunction
endpackage

// file: inc/suc_stream_if.sv
`timescale 1ns/100ps
interface suc_stream_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// file: rtl/suc_buf2.sv
`timescale 1ns/100ps
module suc_buf2 #(parameter int W = 8) (
   input wire logic clk,      // System clock
   input wire logic rst,      // Synchronous reset
   input wire logic ce,       // Clock enable
   suc_stream_if.snk up,      // Filling side
   suc_stream_if.src dn       // Draining side
);
   logic [W-1:0] d0;
   logic [W-1:0] d1;
   logic v0;
   logic v1;
   logic rdy;
   logic push;
   logic pop;

   // Ready is a flop; a full buffer refuses even while it drains
   assign push = up.valid & rdy;
   assign pop = v0 & dn.ready;
   assign up.ready = rdy;
   assign dn.valid = v0;
   assign dn.data = d0;

   // Occupancy
   always_ff @(posedge clk) begin
      if (rst) begin
         v0 <= 1'b0;
         v1 <= 1'b0;
         rdy <= 1'b1;
      end else if (ce) begin
         if (pop) begin
            v0 <= v1 | push;
            v1 <= 1'b0;
            rdy <= 1'b1;
         end else if (push) begin
            v0 <= 1'b1;
            v1 <= v0;
            rdy <= ~v0;  // Mirrors the second slot, kept as a flop
         end
      end
   end

   // Storage, head always read from a register
   always_ff @(posedge clk) begin
      if (ce) begin
         if (pop) begin
            d0 <= v1 ? d1 : up.data;
         end else if (push && !v0) begin
            d0 <= up.data;
         end else if (push) begin
            d1 <= up.data;
         end
      end
   end

   a_buf_keep_full: assert property (@(posedge clk) disable iff (rst || !ce)
      v1 && !pop |=> v1 && $stable(d0))
      else $error("buffer lost a held word");
endmodule

// file: rtl/suc_usart.sv
`timescale 1ns/100ps
// Behaviour
// R1 - A frame carries five to nine data bits and one or two stop bits.
// R2 - Synchronous bit clock runs up to half the system clock.
// R3 - Asynchronous bit rate runs up to an eighth of the system clock.
// R4 - The baud source is a fractional accumulator, any clock will do.
// R5 - Odd or even parity is added on send and checked on receive.
// R6 - Framing error and overrun are found in hardware, each in its own flag.
// R7 - Receive input is majority filtered and false start bits are dropped.
// R8 - Transmit complete, data empty and receive complete are separate lines.
// R9 - In multiprocessor mode data frames are dropped until addressed.
// R10 - Both directions are buffered so frames may follow with no gap.
// R11 - Synchronous slave takes its bit clock from the clock pin.
// R12 - Master SPI drops start, stop and parity but keeps buffers and baud.
// R13 - Master SPI is double buffered, bit order selectable, up to clk/2.
// R14 - Infrared pulses are 3/16 bit, an 8-bit fixed width, or off.
// R15 - Infrared coding works to 115.2 kbps and filters received pulses.
// R16 - The infrared codec can be put in front of this transceiver.
// R17 - Error flags travel with their frame until the data are taken.
module suc_usart
   import suc_pkg::*;
(
   input wire logic clk,               // 40 MHz system clock
   input wire logic rst,               // Synchronous reset, high
   input wire logic ce,                // Clock enable, freezes all state
   input wire suc_mode_t mode,         // Async, sync master/slave, SPI
   input wire logic rx_en,             // Receiver enable
   input wire logic tx_en,             // Transmitter enable
   input wire logic [2:0] char_size,   // 0-3: 5-8 bits, 7: 9 bits
   input wire logic two_stop,          // Two stop bits
   input wire logic par_en,            // Parity enable
   input wire logic par_odd,           // Odd parity when set
   input wire logic mpcm,              // Multiprocessor filter
   input wire logic msb_first,         // SPI bit order
   input wire logic [15:0] baud_step,  // Fractional tick increment
   input wire logic ir_on,             // Infrared codec attached
   input wire suc_ir_t ir_mode,        // Pulse scheme
   input wire logic [7:0] ir_width,    // Fixed pulse width, clocks
   input wire logic [8:0] tx_data,     // Word to send
   input wire logic tx_valid,          // Word offered
   output logic tx_ready,              // Buffer can take a word
   output logic [8:0] rx_data,         // Received word
   output logic rx_valid,              // Word waiting
   input wire logic rx_ready,          // Word taken
   output logic rx_ferr,               // Framing error of this word
   output logic rx_perr,               // Parity error of this word
   output logic rx_ovr,                // Frame lost before this word
   output logic irq_txc,               // Transmit complete
   output logic irq_dre,               // Transmit buffer has room
   output logic irq_rxc,               // Receive complete
   input wire logic rxd_in,            // Serial or infrared input
   output logic txd_out,               // Serial or infrared output
   input wire logic xck_in,            // Clock pin input
   output logic xck_out,               // Clock pin output
   output logic xck_oe_n               // Clock pin enable, low drives
);
   logic is_async;
   logic is_spi;
   logic is_master;
   logic [3:0] n;
   logic [SUC_PH_W-1:0] phase;
   logic tick;
   logic [SUC_TP_W-1:0] tp_cnt;
   logic [SUC_TP_W-1:0] tick_per;
   logic xck_r;
   logic xck_prev;
   logic run_clk;
   logic bit_rise;
   logic bit_fall;
   suc_tx_st_t tx_st;
   logic [SUC_FW-1:0] tx_frame;
   logic [SUC_FW-1:0] tx_sr;
   logic [3:0] tx_len;
   logic [3:0] tx_left;
   logic [2:0] tx_os;
   logic tx_bit;
   logic tx_par;
   logic tx_step;
   logic tx_last;
   logic tx_load;
   suc_rx_st_t rx_st;
   logic rx_line;
   logic vote;
   logic bit_val;
   logic [1:0] smp;
   logic [2:0] rx_os;
   logic [3:0] rx_cnt;
   logic [3:0] rx_total;
   logic [SUC_RW-1:0] rx_bits;
   logic [SUC_RW-1:0] rx_cur;
   logic [SUC_DW-1:0] rx_word;
   logic rx_par;
   logic samp_ev;
   logic rx_fin;
   logic ferr;
   logic perr;
   logic addr_bit;
   logic discard;
   logic ovr_pend;
   logic [SUC_TP_W-1:0] ir_cnt;
   logic [SUC_TP_W:0] ir_316;
   logic [SUC_TP_W-1:0] ir_len;
   logic ir_start;
   logic [1:0] ir_hi;
   logic [2:0] ir_hold;
   logic ir_dec;

   suc_stream_if #(.W(SUC_DW)) tx_in ();
   suc_stream_if #(.W(SUC_DW)) tx_out ();
   suc_stream_if #(.W(SUC_RXE_W)) rx_in ();
   suc_stream_if #(.W(SUC_RXE_W)) rx_out ();

   assign is_async = (mode == SUC_ASYNC);
   assign is_spi = (mode == SUC_SPI_MST);
   assign is_master = (mode == SUC_SYNC_MST) || is_spi;
   assign n = suc_data_len(char_size);

   // Transmit path buffer, two words deep
   assign tx_in.valid = tx_valid;
   assign tx_in.data = tx_data;
   assign tx_ready = tx_in.ready;
   assign irq_dre = tx_in.ready;  // [R8]
   assign tx_out.ready = tx_load;
   suc_buf2 #(.W(SUC_DW)) u_tx_buf (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .up(tx_in),
      .dn(tx_out)
   );  // [R10] [R13]

   // Receive path buffer; error bits ride with their word
   assign rx_out.ready = rx_ready;
   assign rx_valid = rx_out.valid;
   assign irq_rxc = rx_out.valid;  // [R8]
   assign rx_data = rx_out.data[SUC_DW-1:0];
   assign rx_ferr = rx_out.data[SUC_FERR_BIT];  // [R17]
   assign rx_perr = rx_out.data[SUC_PERR_BIT];
   assign rx_ovr = rx_out.data[SUC_OVR_BIT];
   suc_buf2 #(.W(SUC_RXE_W)) u_rx_buf (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .up(rx_in),
      .dn(rx_out)
   );  // [R10]

   // Fractional baud: carry out of the accumulator is the tick
   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= '0;
         tick <= 1'b0;
      end else if (ce) begin
         {tick, phase} <= {1'b0, phase} + {1'b0, baud_step};  // [R4]
      end
   end

   // Tick period in clocks, used to size the 3/16 pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         tp_cnt <= '0;
         tick_per <= '0;
      end else if (ce) begin
         if (tick) begin
            tp_cnt <= '0;
            tick_per <= tp_cnt + 1'b1;
         end else begin
            tp_cnt <= tp_cnt + 1'b1;
         end
      end
   end

   // Bit clock: master toggles per tick, so one bit takes two ticks
   assign run_clk = (mode == SUC_SYNC_MST) || (is_spi && tx_st == SUC_TX_BUSY);
   always_ff @(posedge clk) begin
      if (rst) begin
         xck_r <= 1'b0;
         xck_prev <= 1'b0;
         xck_out <= 1'b0;
         xck_oe_n <= 1'b1;
      end else if (ce) begin
         if (run_clk && tick) begin
            xck_r <= ~xck_r;  // [R2] [R13]
         end else if (!run_clk) begin
            xck_r <= 1'b0;
         end
         xck_prev <= xck_in;
         xck_out <= is_master ? xck_r : 1'b0;
         xck_oe_n <= ~is_master;
      end
   end

   // Sample on rising, shift on falling edges of the bit clock
   always_comb begin
      if (is_master) begin
         bit_rise = run_clk & tick & ~xck_r;
         bit_fall = run_clk & tick & xck_r;
      end else begin
         bit_rise = xck_in & ~xck_prev;  // [R11]
         bit_fall = ~xck_in & xck_prev;
      end
   end

   // Frame image, sent from bit 0 upward
   always_comb begin
      tx_frame = '1;
      tx_par = par_odd;
      tx_len = SUC_SPI_BITS;
      if (is_spi) begin
         for (int i = 0; i < SUC_SPI_W; i++) begin
            tx_frame[i] = msb_first ? tx_out.data[SUC_SPI_W-1-i]
               : tx_out.data[i];  // [R12] [R13]
         end
      end else begin
         tx_frame[0] = 1'b0;
         for (int i = 0; i < SUC_DW; i++) begin
            if (i < n) begin
               tx_frame[i+1] = tx_out.data[i];  // [R1]
               tx_par = tx_par ^ tx_out.data[i];
            end
         end
         if (par_en) begin
            tx_frame[n+1] = tx_par;  // [R5]
         end
         tx_len = n + SUC_START_STOP + {3'b000, par_en}
            + {3'b000, two_stop};  // [R1]
      end
   end

   assign tx_step = (tx_st == SUC_TX_BUSY) && (is_async
      ? (tick && tx_os == SUC_OS_LAST) : bit_fall);  // [R3]
   assign tx_last = tx_step && (tx_left == '0);
   // Next word loads on the very step that ends the last one
   assign tx_load = tx_en && tx_out.valid
      && (tx_st == SUC_TX_IDLE || tx_last);  // [R10]

   // Transmit shifter
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_st <= SUC_TX_IDLE;
         tx_sr <= '0;
         tx_left <= '0;
         tx_os <= '0;
         tx_bit <= 1'b1;
         irq_txc <= 1'b0;
      end else if (ce) begin
         if (tx_load) begin
            tx_st <= SUC_TX_BUSY;
            tx_bit <= tx_frame[0];
            tx_sr <= tx_frame >> 1;
            tx_left <= tx_len - SUC_STOP_BITS;
            tx_os <= '0;
         end else begin
            if (tick) begin
               tx_os <= tx_os + 1'b1;
            end
            if (tx_last) begin
               tx_st <= SUC_TX_IDLE;
               tx_bit <= 1'b1;
            end else if (tx_step) begin
               tx_bit <= tx_sr[0];
               tx_sr <= tx_sr >> 1;
               tx_left <= tx_left - 1'b1;
            end
         end
         if (tx_last && !tx_load) begin
            irq_txc <= 1'b1;  // [R8]
         end else if (tx_load) begin
            irq_txc <= 1'b0;
         end
      end
   end

   // Receive input and three-sample majority on ticks 3, 4, 5
   assign rx_line = (ir_on && is_async) ? ir_dec : rxd_in;  // [R16]
   assign vote = (smp[1] & smp[0]) | (smp[1] & rx_line)
      | (smp[0] & rx_line);  // [R7]
   assign bit_val = is_async ? vote : rx_line;
   assign samp_ev = is_async ? (tick && rx_os == SUC_OS_VOTE) : bit_rise;
   assign rx_total = is_spi ? SUC_SPI_BITS
      : n + SUC_STOP_BITS + {3'b000, par_en};  // [R12]
   assign rx_fin = (rx_st == SUC_RX_BITS) && samp_ev
      && (rx_cnt == rx_total - SUC_STOP_BITS);

   // Word, parity and stop check from stored bits plus the current one
   always_comb begin
      rx_cur = rx_bits;
      rx_cur[rx_cnt] = bit_val;
      rx_word = '0;
      rx_par = par_odd;
      if (is_spi) begin
         for (int i = 0; i < SUC_SPI_W; i++) begin
            rx_word[i] = msb_first ? rx_cur[SUC_SPI_W-1-i] : rx_cur[i];
         end
      end else begin
         for (int i = 0; i < SUC_DW; i++) begin
            if (i < n) begin
               rx_word[i] = rx_cur[i];
               rx_par = rx_par ^ rx_cur[i];
            end
         end
      end
      perr = !is_spi && par_en && (rx_cur[n] != rx_par);  // [R5]
      ferr = !is_spi && !bit_val;  // [R6]
      addr_bit = rx_cur[n-SUC_STOP_BITS];
      discard = mpcm && !is_spi && !addr_bit;  // [R9]
   end

   assign rx_in.valid = rx_fin && !discard;
   assign rx_in.data = {ovr_pend, perr, ferr, rx_word};  // [R17]

   // Receive state machine
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_st <= SUC_RX_IDLE;
         rx_os <= '0;
         rx_cnt <= '0;
         rx_bits <= '0;
         smp <= '1;
      end else if (ce) begin
         if (tick) begin
            smp <= {smp[0], rx_line};
            rx_os <= rx_os + 1'b1;
         end
         case (rx_st)
            SUC_RX_IDLE: begin
               rx_cnt <= '0;
               if (!rx_en) begin
                  rx_st <= SUC_RX_IDLE;
               end else if (is_spi) begin
                  if (tx_load) begin
                     rx_st <= SUC_RX_BITS;
                  end
               end else if (is_async) begin
                  if (tick && !rx_line) begin
                     rx_st <= SUC_RX_START;
                     rx_os <= SUC_OS_FIRST;
                  end
               end else if (bit_rise && !rx_line) begin
                  rx_st <= SUC_RX_BITS;
               end
            end
            SUC_RX_START: begin
               if (!rx_en || (samp_ev && vote)) begin
                  rx_st <= SUC_RX_IDLE;  // [R7]
               end else if (samp_ev) begin
                  rx_st <= SUC_RX_BITS;
               end
            end
            SUC_RX_BITS: begin
               if (!rx_en || rx_fin) begin
                  rx_st <= SUC_RX_IDLE;
               end else if (samp_ev) begin
                  rx_bits[rx_cnt] <= bit_val;
                  rx_cnt <= rx_cnt + 1'b1;
               end
            end
            default: begin
               rx_st <= SUC_RX_IDLE;
            end
         endcase
      end
   end

   // A frame lost to a full buffer marks the next stored word
   always_ff @(posedge clk) begin
      if (rst) begin
         ovr_pend <= 1'b0;
      end else if (ce) begin
         if (rx_fin && !discard && !rx_in.ready) begin
            ovr_pend <= 1'b1;  // [R6]
         end else if (rx_in.valid && rx_in.ready) begin
            ovr_pend <= 1'b0;  // [R17]
         end
      end
   end

   // Infrared encoder: a zero bit becomes one short high pulse
   assign ir_316 = {1'b0, tick_per} + {tick_per, 1'b0};
   assign ir_len = (ir_mode == SUC_IR_FIXED) ? {8'h00, ir_width}
      : ir_316[SUC_TP_W:1];  // [R14]
   assign ir_start = ir_on && is_async && (ir_mode != SUC_IR_OFF)
      && (tx_load ? !tx_frame[0] : (tx_step && !tx_last && !tx_sr[0]));

   always_ff @(posedge clk) begin
      if (rst) begin
         ir_cnt <= '0;
         txd_out <= 1'b1;
      end else if (ce) begin
         if (ir_start) begin
            ir_cnt <= ir_len;  // [R14]
         end else if (ir_cnt != '0) begin
            ir_cnt <= ir_cnt - 1'b1;
         end
         if (ir_on && is_async && ir_mode != SUC_IR_OFF) begin
            txd_out <= (ir_cnt != '0);  // [R16]
         end else begin
            txd_out <= tx_bit;
         end
      end
   end

   // Infrared decoder: a pulse shorter than the filter is ignored,
   // an accepted one reads as zero for most of a bit
   always_ff @(posedge clk) begin
      if (rst) begin
         ir_hi <= '0;
         ir_hold <= '0;
      end else if (ce) begin
         if (!rxd_in) begin
            ir_hi <= '0;
         end else if (ir_hi != SUC_IR_FILT) begin
            ir_hi <= ir_hi + 1'b1;
         end
         if (rxd_in && ir_hi == SUC_IR_FILT - 2'h1) begin
            ir_hold <= SUC_IR_HOLD;  // [R15]
         end else if (tick && ir_hold != '0) begin
            ir_hold <= ir_hold - 1'b1;
         end
      end
   end
   assign ir_dec = (ir_mode == SUC_IR_OFF) ? rxd_in : (ir_hold == '0);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst || !ce);

   sequence s_pulse_out;
      ##1 (ir_cnt != '0) ##1 txd_out;
   endsequence

   sequence s_async_quiet;
      !tx_step [*7];
   endsequence

   a_false_start_drop: assert property (  // [R7]
      rx_st == SUC_RX_START && samp_ev && vote |=> rx_st == SUC_RX_IDLE)
      else $error("false start bit not rejected");
   a_async_bit_len: assert property (  // [R3]
      is_async && tx_step && !tx_last |=> s_async_quiet)
      else $error("async bit shorter than eight clocks");
   a_sync_clk_tick: assert property (  // [R2]
      is_master && run_clk && $changed(xck_r) |-> $past(tick))
      else $error("bit clock moved without a tick");
   a_overrun_mark: assert property (  // [R6]
      rx_fin && !discard && !rx_in.ready |=> ovr_pend)
      else $error("lost frame not flagged");
   a_mpcm_drop: assert property (  // [R9]
      rx_fin && mpcm && !is_spi && !addr_bit && !rx_out.valid
      |=> !rx_out.valid)
      else $error("unaddressed frame stored");
   a_tx_no_gap: assert property (  // [R10]
      tx_last && tx_en && tx_out.valid |=> tx_st == SUC_TX_BUSY && !irq_txc)
      else $error("gap between buffered frames");
   a_txc_raise: assert property (  // [R8]
      tx_last && !tx_out.valid |=> irq_txc && tx_st == SUC_TX_IDLE)
      else $error("transmit complete not raised");
   a_line_idle: assert property (  // [R1]
      tx_st == SUC_TX_IDLE && !tx_load |=> tx_bit)
      else $error("line not idle high");
   a_ir_pulse: assert property (  // [R14]
      ir_start && ir_len > 16'h0001 |-> s_pulse_out)
      else $error("infrared pulse not emitted");
endmodule

// file: dv/suc_peer.sv
`timescale 1ns/100ps
module suc_peer #(parameter int BT = 16) (
   input wire logic clk, // System clock
   input wire logic txd, // Line from the device
   output logic rxd      // Line into the device, pulled up when idle
);
   initial rxd = 1'b1;

   // Start bit, then n bits LSB first; line goes back to idle high
   task automatic send(input logic [11:0] w, input int n);
      @(posedge clk);
      rxd <= 1'b0;
      repeat (BT) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         rxd <= w[i];
         repeat (BT) @(posedge clk);
      end
      rxd <= 1'b1;
   endtask

   // Short low pulse, far below half a bit, to fake a start
   task automatic glitch(input int n);
      @(posedge clk);
      rxd <= 1'b0;
      repeat (n) @(posedge clk);
      rxd <= 1'b1;
   endtask

   // Samples each bit mid-cell, timed from the start edge
   task automatic recv(output logic [11:0] w, input int n);
      w = '0;
      while (txd !== 1'b0) @(posedge clk);
      repeat (BT / 2) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         repeat (BT) @(posedge clk);
         w[i] = txd;
      end
   endtask
endmodule

// file: dv/serial_usart_with_ir_codec_test.sv
`timescale 1ns/100ps
module serial_usart_with_ir_codec_test;
   import suc_pkg::*;
   logic clk, rst, ce, rx_en, tx_en, two_stop, par_en, par_odd, mpcm;
   logic msb_first, ir_on, tx_valid, rx_ready, xck_in;
   suc_mode_t mode;
   suc_ir_t ir_mode;
   logic [2:0] char_size;
   logic [15:0] baud_step;
   logic [7:0] ir_width;
   logic [8:0] tx_data, rx_data;
   logic tx_ready, rx_valid, rx_ferr, rx_perr, rx_ovr;
   logic irq_txc, irq_dre, irq_rxc, rxd_in, txd_out, xck_out, xck_oe_n;
   logic [11:0] b;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;

   // Port names match the bench signals one for one
   suc_usart u_suc_usart (.*);
   suc_peer #(.BT(16)) u_suc_peer (.clk(clk), .txd(txd_out), .rxd(rxd_in));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic give_verdict;
      $display("tests %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Whole run needs about 2400 cycles; a hang stops here
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fail_count++;
         give_verdict();
      end
   end

   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Bounded wait; the caller judges the flag afterwards
   task automatic wait_sig(ref logic s);
      for (int i = 0; i < 400 && s !== 1'b1; i++) @(posedge clk);
   endtask

   // Frame format: size, parity on, odd, two stops, address filter
   task automatic cfg(input logic [6:0] v);
      @(posedge clk);
      {char_size, par_en, par_odd, two_stop, mpcm} <= v;
   endtask

   task automatic pop;
      @(posedge clk);
      rx_ready <= 1'b1;
      @(posedge clk);
      rx_ready <= 1'b0;
   endtask

   // Head word with its flags, {ovr, perr, ferr, data}, then taken
   task automatic rx_chk(input logic [11:0] exp);
      wait_sig(rx_valid);
      #1;
      chk({rx_ovr, rx_perr, rx_ferr, rx_data}, exp);
      pop();
   endtask

   task automatic t_reset;
      #1;
      chk({tx_ready, rx_valid, txd_out, xck_oe_n, irq_txc, irq_dre,
         irq_rxc}, 7'h5A);
   endtask

   // Two words queued at once leave in order with even parity
   task automatic t_tx;
      cfg(7'h38);
      fork
         begin
            u_suc_peer.recv(b, 10);
            chk(b, {2'h0, 1'b1, ^8'hA5, 8'hA5});
            u_suc_peer.recv(b, 10);
            chk(b, {2'h0, 1'b1, ^8'h07, 8'h07});
         end
         begin
            @(posedge clk);
            tx_data <= 9'h0A5;
            tx_valid <= 1'b1;
            @(posedge clk);
            tx_data <= 9'h007;
            @(posedge clk);
            tx_valid <= 1'b0;
         end
      join
      wait_sig(irq_txc);
      chk(irq_txc, 1'b1);
   endtask

   // Odd parity good, then bad, then a low stop bit
   task automatic t_rx_err;
      cfg(7'h3C);
      u_suc_peer.send(12'h35A, 10);
      rx_chk(12'h05A);
      u_suc_peer.send(12'h25A, 10);
      rx_chk(12'h45A);
      u_suc_peer.send(12'h15A, 10);
      rx_chk(12'h25A);
   endtask

   // Third frame finds both slots full; loss shows on the next word
   task automatic t_ovr;
      cfg(7'h02);
      u_suc_peer.send(12'h071, 7);
      u_suc_peer.send(12'h06A, 7);
      u_suc_peer.send(12'h075, 7);
      rx_chk(12'h011);
      rx_chk(12'h00A);
      u_suc_peer.send(12'h07F, 7);
      rx_chk(12'h81F);
   endtask

   // Data frame dropped while unaddressed, address frame kept
   task automatic t_mpcm;
      cfg(7'h71);
      u_suc_peer.send(12'h255, 10);
      repeat (20) @(posedge clk);
      chk(rx_valid, 1'b0);
      u_suc_peer.send(12'h3A3, 10);
      wait_sig(rx_valid);
      chk(irq_rxc, 1'b1);
      rx_chk(12'h1A3);
   endtask

   // A short low spike must not start a frame
   task automatic t_false;
      cfg(7'h30);
      u_suc_peer.glitch(3);
      repeat (200) @(posedge clk);
      chk(rx_valid, 1'b0);
      u_suc_peer.send(12'h1C3, 9);
      rx_chk(12'h0C3);
   endtask

   // Master SPI, msb first; idle-high line reads back as all ones
   task automatic t_spi;
      @(posedge clk);
      mode <= SUC_SPI_MST;
      msb_first <= 1'b1;
      tx_data <= 9'h080;
      tx_valid <= 1'b1;
      @(posedge clk);
      tx_valid <= 1'b0;
      wait_sig(xck_out);
      #1;
      chk({xck_oe_n, txd_out}, 2'h1);
      @(posedge clk);
      #1;
      chk(xck_out, 1'b0);
      rx_chk(12'h0FF);
   endtask

   // Fixed-width infrared: all-ones byte leaves one pulse, the start bit
   task automatic t_ir;
      logic [11:0] hi;
      hi = '0;
      @(posedge clk);
      mode <= SUC_ASYNC;
      ir_on <= 1'b1;
      ir_mode <= SUC_IR_FIXED;
      ir_width <= 8'h04;
      tx_data <= 9'h0FF;
      tx_valid <= 1'b1;
      @(posedge clk);
      tx_valid <= 1'b0;
      repeat (200) begin
         @(posedge clk);
         hi = hi + {11'h000, txd_out};
      end
      chk(hi, 12'h004);
   endtask

   initial begin
      {rst, ce, rx_en, tx_en, tx_valid, rx_ready, xck_in} = 7'h78;
      {two_stop, par_en, par_odd, mpcm, msb_first, ir_on} = '0;
      char_size = 3'h3;
      mode = SUC_ASYNC;
      ir_mode = SUC_IR_OFF;
      ir_width = 8'h00;
      tx_data = '0;
      baud_step = 16'h8000;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_tx();
      t_rx_err();
      t_ovr();
      t_mpcm();
      t_false();
      t_spi();
      t_ir();
      give_verdict();
   end
endmodule
